// File: hw/system_power_state_machine.sv
// Purpose: global power-state controller (C0, Cx, S3, S4, S5, deep sleep, G3)
// Assumes: always-on clock; pin events synchronised here; msg/reg inputs are on-clock
// Notes: one transition at most per cycle
// Notes on behaviour
// - C0/Cx change only on interconnect messages, acting on their content.
// - in C0, sleep enable bit moves to the software-chosen sleep state.
// - power button override in C0, Cx, S3, S4 forces S5.
// - power failure in any powered state goes to G3; no wakes there.
// - enabled wake in S3, S4, S5 or deep sleep returns to C0.
// - from S3/S4/S5 enter deep sleep when its entry conditions hold.
// - remember sleep state left for deep sleep; AC present resumes it.
// - power return picks C0 or S5 from prior state and config bit.
// - staying in S5 after power return waits for wake; button override is ignored in S5.
// - S3 keeps memory powered, stops all clocks except real-time clock.
// - S4 keeps only resume logic powered.
// - wake from S5 starts a full boot.
// - intermediate states during a transition are not separate transitions.
// - S4 sleep output high in S3, low in S4 and S5.
// - S5 sleep output high in S3 and S4, low in S5.
// - override entry into S5 continues to deep sleep if enabled and ready.
`timescale 1ns/1ps
module system_power_state_machine (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic msg_valid,
  input wire logic msg_enter_cx,
  input wire logic sleep_enable_bit,
  input wire logic [1:0] sleep_type,
  input wire logic pwrbtn_override,
  input wire logic power_fail,
  input wire logic power_return,
  input wire logic wake_event,
  input wire logic ac_present_input,
  input wire logic dsx_enable,
  input wire logic dsx_cond_met,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  output logic [31:0] reg_rdata,
  output logic sleep_s3_out_n,
  output logic sleep_s4_out_n,
  output logic sleep_s5_out_n,
  output logic mem_power_en,
  output logic ext_clk_en,
  output logic full_boot,
  output logic [6:0] power_state
);
  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisation
  logic [4:0] pin_raw;
  logic [4:0] pin_s;
  logic pbo_s;
  logic fail_s;
  logic ret_s;
  logic wake_s;
  logic acp_s;

  assign pin_raw = {pwrbtn_override, power_fail, power_return, wake_event, ac_present_input};

  sync2 #(.W(5)) pin_sync (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .d(pin_raw),
    .q(pin_s)
  );

  assign {pbo_s, fail_s, ret_s, wake_s, acp_s} = pin_s;

  ////////////////////////////////////////////////////////////////////////////
  // state registers
  power_state_pkg::pwr_state_t state_r;
  power_state_pkg::pwr_state_t state_nxt;
  power_state_pkg::pwr_state_t pre_g3_r;
  power_state_pkg::pwr_state_t pre_g3_nxt;
  power_state_pkg::pwr_state_t dsx_from_r;
  power_state_pkg::pwr_state_t dsx_from_nxt;
  logic [31:0] cfg3_r;
  logic [31:0] cfg3_nxt;
  logic full_boot_r;
  logic full_boot_nxt;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic acp_d_r;
  logic acp_rise;
  logic after_loss_off;
  logic dsx_go;
  power_state_pkg::pwr_state_t sleep_tgt;

  assign acp_rise = acp_s & ~acp_d_r;
  assign after_loss_off = cfg3_r[power_state_pkg::AFTER_LOSS_BIT];
  assign dsx_go = dsx_enable & dsx_cond_met;

  // decode the software sleep type
  always_comb begin
    case (sleep_type)
      power_state_pkg::SLP_TYPE_S3: sleep_tgt = power_state_pkg::ST_S3;
      power_state_pkg::SLP_TYPE_S4: sleep_tgt = power_state_pkg::ST_S4;
      default: sleep_tgt = power_state_pkg::ST_S5;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // power-state next value; failure first, then override, then the rest
  always_comb begin
    state_nxt = state_r;
    pre_g3_nxt = pre_g3_r;
    dsx_from_nxt = dsx_from_r;
    full_boot_nxt = 1'b0;
    case (state_r)
      power_state_pkg::ST_C0: begin
        if (fail_s) begin
          state_nxt = power_state_pkg::ST_G3;
        end else if (pbo_s) begin
          state_nxt = dsx_go ? power_state_pkg::ST_DSX : power_state_pkg::ST_S5;
          dsx_from_nxt = power_state_pkg::ST_S5;
        end else if (sleep_enable_bit) begin
          state_nxt = sleep_tgt;  // direct, no intermediate stop
        end else if (msg_valid && msg_enter_cx) begin
          state_nxt = power_state_pkg::ST_CX;
        end
      end
      power_state_pkg::ST_CX: begin
        if (fail_s) begin
          state_nxt = power_state_pkg::ST_G3;
        end else if (pbo_s) begin
          state_nxt = dsx_go ? power_state_pkg::ST_DSX : power_state_pkg::ST_S5;
          dsx_from_nxt = power_state_pkg::ST_S5;
        end else if (msg_valid && !msg_enter_cx) begin
          state_nxt = power_state_pkg::ST_C0;
        end
      end
      power_state_pkg::ST_S3, power_state_pkg::ST_S4, power_state_pkg::ST_S5: begin
        if (fail_s) begin
          state_nxt = power_state_pkg::ST_G3;
        end else if (pbo_s && state_r != power_state_pkg::ST_S5) begin
          state_nxt = dsx_go ? power_state_pkg::ST_DSX : power_state_pkg::ST_S5;
          dsx_from_nxt = power_state_pkg::ST_S5;
        end else if (wake_s) begin
          state_nxt = power_state_pkg::ST_C0;
          full_boot_nxt = (state_r == power_state_pkg::ST_S5);
        end else if (dsx_go) begin
          state_nxt = power_state_pkg::ST_DSX;
          dsx_from_nxt = state_r;
        end
      end
      power_state_pkg::ST_DSX: begin
        if (fail_s) begin
          state_nxt = power_state_pkg::ST_G3;
        end else if (wake_s) begin
          state_nxt = power_state_pkg::ST_C0;
          full_boot_nxt = (dsx_from_r == power_state_pkg::ST_S5);
        end else if (acp_rise) begin
          state_nxt = dsx_from_r;
        end
      end
      power_state_pkg::ST_G3: begin
        // wake events ignored here
        if (ret_s) begin
          if (after_loss_off || pre_g3_r == power_state_pkg::ST_S5 ||
              pre_g3_r == power_state_pkg::ST_DSX) begin
            state_nxt = power_state_pkg::ST_S5;
          end else begin
            state_nxt = power_state_pkg::ST_C0;
            full_boot_nxt = 1'b1;
          end
        end
      end
      default: state_nxt = power_state_pkg::ST_G3;
    endcase
    if (state_r != power_state_pkg::ST_G3 && state_nxt == power_state_pkg::ST_G3) begin
      pre_g3_nxt = state_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // configuration register at its printed offset
  always_comb begin
    cfg3_nxt = cfg3_r;
    rdata_nxt = rdata_r;
    if (reg_wr && reg_addr == power_state_pkg::GEN_CFG3_OFFSET) begin
      cfg3_nxt = reg_wdata & power_state_pkg::GEN_CFG3_WMASK;
    end
    if (reg_rd) begin
      rdata_nxt = (reg_addr == power_state_pkg::GEN_CFG3_OFFSET) ? cfg3_r : 32'h0000_0000;
    end
  end

  // always-on registers
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state_r <= power_state_pkg::ST_G3;
      pre_g3_r <= power_state_pkg::ST_S5;
      dsx_from_r <= power_state_pkg::ST_S5;
      cfg3_r <= power_state_pkg::GEN_CFG3_RESET;
      full_boot_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      acp_d_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      pre_g3_r <= pre_g3_nxt;
      dsx_from_r <= dsx_from_nxt;
      cfg3_r <= cfg3_nxt;
      full_boot_r <= full_boot_nxt;
      rdata_r <= rdata_nxt;
      acp_d_r <= acp_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sleep outputs; deep sleep keeps the pins of the state it came from
  logic s3_sleep;
  logic s4_sleep;
  logic s5_sleep;
  assign s3_sleep = (state_r == power_state_pkg::ST_S3) ||
                    (state_r == power_state_pkg::ST_DSX && dsx_from_r == power_state_pkg::ST_S3);
  assign s4_sleep = (state_r == power_state_pkg::ST_S4) ||
                    (state_r == power_state_pkg::ST_DSX && dsx_from_r == power_state_pkg::ST_S4);
  assign s5_sleep = (state_r == power_state_pkg::ST_S5) || (state_r == power_state_pkg::ST_G3) ||
                    (state_r == power_state_pkg::ST_DSX && dsx_from_r == power_state_pkg::ST_S5);

  assign sleep_s3_out_n = ~(s3_sleep | s4_sleep | s5_sleep);
  assign sleep_s4_out_n = ~(s4_sleep | s5_sleep);
  assign sleep_s5_out_n = ~s5_sleep;
  assign mem_power_en = (state_r == power_state_pkg::ST_C0) ||
                        (state_r == power_state_pkg::ST_CX) || s3_sleep;
  assign ext_clk_en = (state_r == power_state_pkg::ST_C0) ||
                      (state_r == power_state_pkg::ST_CX);
  assign full_boot = full_boot_r;
  assign reg_rdata = rdata_r;
  assign power_state = state_r;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  sequence fail_seen_s;
    fail_s && state_r != power_state_pkg::ST_G3;
  endsequence
  sequence in_g3_s;
    state_r == power_state_pkg::ST_G3;
  endsequence

  power_fail_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    fail_seen_s |=> in_g3_s) else $error("power failure did not reach g3");
  g3_wake_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    in_g3_s and !ret_s |=> in_g3_s) else $error("left g3 without power return");
  cx_msg_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $changed(state_r) && $past(state_r) == power_state_pkg::ST_CX &&
    state_r == power_state_pkg::ST_C0 |-> $past(msg_valid)) else $error("cx exit without msg");
  sleep_en_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    state_r == power_state_pkg::ST_C0 && sleep_enable_bit && !fail_s && !pbo_s
    |=> state_r == $past(sleep_tgt)) else $error("sleep enable ignored");
  override_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    state_r == power_state_pkg::ST_S3 && pbo_s && !fail_s && !dsx_go
    |=> state_r == power_state_pkg::ST_S5) else $error("override did not give s5");
  wake_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    state_r == power_state_pkg::ST_S4 && wake_s && !fail_s && !pbo_s
    |=> state_r == power_state_pkg::ST_C0) else $error("wake from s4 missed");
  dsx_resume_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    state_r == power_state_pkg::ST_DSX && acp_rise && !fail_s && !wake_s
    |=> state_r == $past(dsx_from_r)) else $error("deep sleep resume wrong");
  pins_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    state_r == power_state_pkg::ST_S3 |-> sleep_s4_out_n && sleep_s5_out_n && !ext_clk_en)
    else $error("s3 pin levels wrong");
  s5_pins_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    state_r == power_state_pkg::ST_S5 |-> !sleep_s4_out_n && !sleep_s5_out_n)
    else $error("s5 pin levels wrong");
  return_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    in_g3_s and ret_s and after_loss_off |=> state_r == power_state_pkg::ST_S5)
    else $error("power return ignored config");
endmodule

// File: hw/power_state_pkg.sv
// Purpose: shared constants and state encoding for the system power-state controller
// Assumes: one 200 MHz always-on clock
// Notes: register offset and bit layout of the power-loss configuration word
package power_state_pkg;
  // register map
  localparam logic [7:0] GEN_CFG3_OFFSET = 8'ha4;
  localparam int AFTER_LOSS_BIT = 0;  // after_power_loss_select position
  localparam logic [31:0] GEN_CFG3_RESET = 32'h0000_0000;
  localparam logic [31:0] GEN_CFG3_WMASK = 32'h0000_0001;

  // sleep type codes as software writes them
  localparam logic [1:0] SLP_TYPE_S3 = 2'h3;
  localparam logic [1:0] SLP_TYPE_S4 = 2'h2;
  localparam logic [1:0] SLP_TYPE_S5 = 2'h1;

  // one-hot power states
  typedef enum logic [6:0] {
    ST_C0 = 7'b000_0001,
    ST_CX = 7'b000_0010,
    ST_S3 = 7'b000_0100,
    ST_S4 = 7'b000_1000,
    ST_S5 = 7'b001_0000,
    ST_DSX = 7'b010_0000,
    ST_G3 = 7'b100_0000
  } pwr_state_t;
endpackage

// File: hw/sync2.sv
// Purpose: two-flop synchroniser for pin inputs
// Assumes: inputs arrive asynchronously to sys_clk
// Notes: first stage is read only by the second
`timescale 1ns/1ps
module sync2 #(
  parameter int W = 1
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_r;
  logic [W-1:0] meta_nxt;
  logic [W-1:0] q_nxt;

  // next values
  always_comb begin
    meta_nxt = d;
    q_nxt = meta_r;
  end

  // register stages
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      meta_r <= '0;
      q <= '0;
    end else begin
      meta_r <= meta_nxt;
      q <= q_nxt;
    end
  end
endmodule

// File: dv/host_msg_model.sv
// Purpose: host processor model sending c-state messages on the package interconnect
// Assumes: called just after a falling clock edge
// Notes: the content line shows the inverse of its last value between messages
`timescale 1ns/1ps
module host_msg_model (
  input wire logic sys_clk,
  output logic msg_valid,
  output logic msg_enter_cx
);
  // line idles low until the first message
  initial begin
    msg_valid = 1'b0;
    msg_enter_cx = 1'b0;
  end

  // one-cycle strobe, optionally after a stall of a few cycles
  task automatic send_msg(input logic cx, input logic slow);
    if (slow) repeat (3) @(negedge sys_clk);
    msg_valid = 1'b1;
    msg_enter_cx = cx;  // device acts on this content only
    @(negedge sys_clk);
    msg_valid = 1'b0;
    msg_enter_cx = ~cx;  // released line no longer shows the value
    @(negedge sys_clk);  // idle gap so a following message never re-raises in this step
  endtask
endmodule

// File: dv/system_power_state_machine_tb.sv
// Purpose: self-checking bench for the power-state controller
// Assumes: inputs driven at the falling edge; seed fixed
// Notes: pins are pulsed long enough to pass the synchroniser
`timescale 1ns/1ps
module system_power_state_machine_tb;
  logic sys_clk, rst_n, sleep_enable_bit, dsx_enable, dsx_cond_met, reg_wr, reg_rd;
  logic msg_valid, msg_enter_cx, sleep_s3_out_n, sleep_s4_out_n, sleep_s5_out_n;
  logic mem_power_en, ext_clk_en, full_boot;
  logic [1:0] sleep_type;
  logic [4:0] pins;  // override, fail, return, wake, ac present
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  logic [6:0] power_state;
  int err_count = 0;
  int total_checks = 0;
  int boot_cnt = 0;  // full boot pulses seen so far
  int boot_base = 0;  // count at the start of a boot check
  int rot;  // random start of the sleep-type sweep

  system_power_state_machine i_dut (.sys_clk(sys_clk), .rst_n(rst_n), .msg_valid(msg_valid),
    .msg_enter_cx(msg_enter_cx), .sleep_enable_bit(sleep_enable_bit), .sleep_type(sleep_type),
    .pwrbtn_override(pins[0]), .power_fail(pins[1]), .power_return(pins[2]),
    .wake_event(pins[3]), .ac_present_input(pins[4]), .dsx_enable(dsx_enable),
    .dsx_cond_met(dsx_cond_met), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .sleep_s3_out_n(sleep_s3_out_n),
    .sleep_s4_out_n(sleep_s4_out_n), .sleep_s5_out_n(sleep_s5_out_n),
    .mem_power_en(mem_power_en), .ext_clk_en(ext_clk_en), .full_boot(full_boot),
    .power_state(power_state));
  host_msg_model i_host (.sys_clk(sys_clk), .msg_valid(msg_valid), .msg_enter_cx(msg_enter_cx));

  ////////////////////////////////////////////////////////////////////////////////
  // clock, and a count of boot pulses taken while they stand
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) if (full_boot === 1'b1) boot_cnt <= boot_cnt + 1;

  ////////////////////////////////////////////////////////////////////////////////
  // expectations
  function automatic power_state_pkg::pwr_state_t sleep_of(input logic [1:0] t);
    if (t == power_state_pkg::SLP_TYPE_S3) return power_state_pkg::ST_S3;
    if (t == power_state_pkg::SLP_TYPE_S4) return power_state_pkg::ST_S4;
    return power_state_pkg::ST_S5;
  endfunction
  function automatic logic [4:0] outs_of(input power_state_pkg::pwr_state_t s);
    case (s)
      power_state_pkg::ST_C0: return 5'h1f;
      power_state_pkg::ST_CX: return 5'h1f;  // idle processor keeps full power
      power_state_pkg::ST_S3: return 5'h0e;  // memory kept, clocks stopped
      power_state_pkg::ST_S4: return 5'h04;
      default: return 5'h00;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // shared tasks
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic go(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  task automatic pin(input int i);
    pins[i] = 1'b1;
    go(4);
    pins[i] = 1'b0;
    go(1);
  endtask
  task automatic wait_st(input power_state_pkg::pwr_state_t s);
    for (int k = 0; k < 10 && power_state !== s; k++) go(1);
    check(32'(power_state), 32'(s));
  endtask
  task automatic check_outs(input power_state_pkg::pwr_state_t s);
    check(32'({sleep_s3_out_n, sleep_s4_out_n, sleep_s5_out_n, mem_power_en, ext_clk_en}),
      32'(outs_of(s)));
  endtask
  task automatic reg_acc(input logic wr, input logic [7:0] a, input logic [31:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = wr;
    reg_rd = ~wr;
    go(1);
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    go(1);
  endtask
  task automatic done(input string name);
    $display("test %s done", name);
  endtask
  task automatic final_report;
    $display("checks=%0d mismatches=%0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // watchdog
  initial begin
    #200000;
    err_count++;
    final_report();
  end

  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    {rst_n, sleep_enable_bit, dsx_enable, dsx_cond_met, reg_wr, reg_rd} = '0;
    {sleep_type, pins, reg_addr, reg_wdata} = '0;
    void'($urandom(32'h880f_23ec));
    go(5);
    rst_n = 1'b1;
    wait_st(power_state_pkg::ST_G3);
    check_outs(power_state_pkg::ST_G3);
    reg_acc(1'b1, power_state_pkg::GEN_CFG3_OFFSET, $urandom() | 32'h0000_0001);
    reg_acc(1'b0, power_state_pkg::GEN_CFG3_OFFSET, 32'h0000_0000);
    check(reg_rdata, 32'h0000_0001);
    reg_acc(1'b0, 8'($urandom_range(0, 8'ha3)), 32'h0000_0000);
    check(reg_rdata, 32'h0000_0000);
    done("register");
    pin(2);
    wait_st(power_state_pkg::ST_S5);
    go(10);
    check(32'(power_state), 32'(power_state_pkg::ST_S5));
    check_outs(power_state_pkg::ST_S5);
    pin(3);
    wait_st(power_state_pkg::ST_C0);
    check(32'(boot_cnt - boot_base), 32'h1);
    done("power_return");
    i_host.send_msg(1'b1, 1'($urandom()));
    wait_st(power_state_pkg::ST_CX);
    check_outs(power_state_pkg::ST_CX);
    i_host.send_msg(1'b0, 1'($urandom()));
    wait_st(power_state_pkg::ST_C0);
    check_outs(power_state_pkg::ST_C0);
    done("messages");
    rot = $urandom_range(0, 3);
    for (int i = 0; i < 4; i++) begin
      sleep_type = 2'((i + rot) % 4);  // every code, the unlisted one included
      sleep_enable_bit = 1'b1;
      go(1);
      sleep_enable_bit = 1'b0;
      wait_st(sleep_of(sleep_type));
      check_outs(sleep_of(sleep_type));
      boot_base = boot_cnt;
      go($urandom_range(1, 4));
      pin(3);
      wait_st(power_state_pkg::ST_C0);
      check(32'(boot_cnt - boot_base), 32'(sleep_of(sleep_type) == power_state_pkg::ST_S5));
    end
    pin(0);
    wait_st(power_state_pkg::ST_S5);
    done("sleep");
    pin(3);
    sleep_type = power_state_pkg::SLP_TYPE_S3;
    sleep_enable_bit = 1'b1;
    go(1);
    sleep_enable_bit = 1'b0;
    wait_st(power_state_pkg::ST_S3);
    {dsx_enable, dsx_cond_met} = 2'b11;
    wait_st(power_state_pkg::ST_DSX);
    check_outs(power_state_pkg::ST_S3);
    dsx_cond_met = 1'b0;
    pin(4);
    wait_st(power_state_pkg::ST_S3);
    pin(0);
    wait_st(power_state_pkg::ST_S5);
    pin(3);
    wait_st(power_state_pkg::ST_C0);
    dsx_cond_met = 1'b1;
    pin(0);
    wait_st(power_state_pkg::ST_DSX);
    {dsx_enable, dsx_cond_met} = 2'b00;
    pin(4);
    wait_st(power_state_pkg::ST_S5);
    done("deep_sleep");
    reg_acc(1'b1, power_state_pkg::GEN_CFG3_OFFSET, 32'h0000_0000);
    pin(3);
    wait_st(power_state_pkg::ST_C0);
    pin(1);
    wait_st(power_state_pkg::ST_G3);
    pin(3);
    check(32'(power_state), 32'(power_state_pkg::ST_G3));
    boot_base = boot_cnt;
    pin(2);
    wait_st(power_state_pkg::ST_C0);
    check(32'(boot_cnt - boot_base), 32'h1);
    done("power_fail");
    // loss from full-on with the stay-off bit set must come back in soft-off
    reg_acc(1'b1, power_state_pkg::GEN_CFG3_OFFSET, 32'h0000_0001);
    pin(1);
    wait_st(power_state_pkg::ST_G3);
    pin(2);
    wait_st(power_state_pkg::ST_S5);
    check_outs(power_state_pkg::ST_S5);
    done("power_loss_stay_off");
    final_report();
  end
endmodule
